// File: src/txb_bank.sv
// one 256 x 160 dual-port bank with registered read
`timescale 1ns/100ps
module txb_bank (
	input wire logic clock,
	input wire logic rst,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [159:0] wdata,
	input wire logic re,
	input wire logic [7:0] raddr,
	output logic [159:0] rdata
);
	logic [159:0] mem [txb_pkg::BANK_LINES];
	logic [159:0] rdata_r;
	logic [159:0] rdata_nxt;

	assign rdata = rdata_r;

	always_comb begin
		rdata_nxt = rdata_r;
		if (re) begin
			rdata_nxt = mem[raddr];
		end
	end

	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_r <= 160'h0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
endmodule

// File: src/txb_fifo_banks.sv
// partitioned transmit buffer: registers, pointers, full flags, read port
`timescale 1ns/100ps
module txb_fifo_banks #(
	parameter bit USE_SECOND = 1'b0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [19:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] wr_en,
	input wire logic [11:0] wr_part,
	input wire logic [127:0] wr_data,
	input wire logic [31:0] wr_ctrl,
	output logic [31:0] part_full,
	input wire logic rd_req,
	input wire logic [1:0] rd_bank,
	input wire logic [2:0] rd_part,
	output logic rd_valid,
	output logic [127:0] rd_data,
	output logic [31:0] rd_ctrl,
	output logic rd_empty,
	output logic irq
);
	// configuration and interrupt registers
	logic [7:0] agg_first_r;
	logic [7:0] agg_first_nxt;
	logic [7:0] part_first_r;
	logic [7:0] part_first_nxt;
	logic [7:0] agg_second_r;
	logic [7:0] agg_second_nxt;
	logic [7:0] part_second_r;
	logic [7:0] part_second_nxt;
	logic [7:0] thresh_r;
	logic [7:0] thresh_nxt;
	logic [7:0] int_stat_r;
	logic [7:0] int_stat_nxt;
	logic [7:0] int_mask_r;
	logic [7:0] int_mask_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic irq_r;
	logic irq_nxt;
	logic [7:0] agg_sel;
	logic [7:0] part_sel;
	logic [1:0] agg_b [4];
	logic [1:0] pc_b [4];
	logic [9:0] depth_b [4];

	// pointer state, one entry per bank and partition
	logic [9:0] level_r [txb_pkg::NUM_FIFOS];
	logic [9:0] level_nxt [txb_pkg::NUM_FIFOS];
	logic [8:0] wptr_r [txb_pkg::NUM_FIFOS];
	logic [8:0] wptr_nxt [txb_pkg::NUM_FIFOS];
	logic [8:0] rptr_r [txb_pkg::NUM_FIFOS];
	logic [8:0] rptr_nxt [txb_pkg::NUM_FIFOS];
	logic [31:0] full_r;
	logic [31:0] full_nxt;
	logic [7:0] events;

	// memory ports
	logic mem_we [4];
	logic [7:0] mem_waddr [4];
	logic [159:0] mem_wdata [4];
	logic mem_re [4];
	logic [7:0] mem_raddr [4];
	logic [159:0] mem_rdata [4];

	// read pipeline
	logic rd_pend_r;
	logic rd_pend_nxt;
	logic [1:0] rd_sel_r;
	logic [1:0] rd_sel_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic [159:0] rd_line_r;
	logic [159:0] rd_line_nxt;
	logic rd_empty_r;
	logic rd_empty_nxt;

	txb_line_if lines [4] ();

	// one register set steers this interface's banks
	assign agg_sel = USE_SECOND ? agg_second_r : agg_first_r;
	assign part_sel = USE_SECOND ? part_second_r : part_first_r;

	genvar g;
	generate
		for (g = 0; g < txb_pkg::NUM_BANKS; g++) begin : gen_bank
			assign agg_b[g] = agg_sel[g*2 +: 2];
			assign pc_b[g] = part_sel[g*2 +: 2];
			assign depth_b[g] = txb_pkg::txb_depth(agg_b[g], pc_b[g]);

			txb_line_asm u_asm (
				.clock(clock),
				.rst(rst),
				.agg(agg_b[g]),
				.wr_en(wr_en[g]),
				.wr_part(wr_part[g*3 +: 3]),
				.wr_data(128'(wr_data >> (g*32))),
				.wr_ctrl(32'(wr_ctrl >> (g*8))),
				.out(lines[g])
			);

			txb_bank u_bank (
				.clock(clock),
				.rst(rst),
				.we(mem_we[g]),
				.waddr(mem_waddr[g]),
				.wdata(mem_wdata[g]),
				.re(mem_re[g]),
				.raddr(mem_raddr[g]),
				.rdata(mem_rdata[g])
			);
		end
	endgenerate

	logic line_valid [4];
	logic [2:0] line_part [4];
	logic [159:0] line_data [4];
	generate
		for (g = 0; g < txb_pkg::NUM_BANKS; g++) begin : gen_line
			assign line_valid[g] = lines[g].valid;
			assign line_part[g] = lines[g].part;
			assign line_data[g] = lines[g].line;
		end
	endgenerate

	// register bus
	always_comb begin
		agg_first_nxt = agg_first_r;
		part_first_nxt = part_first_r;
		agg_second_nxt = agg_second_r;
		part_second_nxt = part_second_r;
		thresh_nxt = thresh_r;
		int_mask_nxt = int_mask_r;
		rdata_nxt = 8'h00;
		if (reg_wr) begin
			unique case (reg_addr)
				txb_pkg::OFS_AGG_FIRST: agg_first_nxt = reg_wdata;
				txb_pkg::OFS_PART_FIRST: part_first_nxt = reg_wdata;
				txb_pkg::OFS_AGG_SECOND: agg_second_nxt = reg_wdata;
				txb_pkg::OFS_PART_SECOND: part_second_nxt = reg_wdata;
				txb_pkg::OFS_THRESH: thresh_nxt = reg_wdata;
				txb_pkg::OFS_INT_MASK: int_mask_nxt = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				txb_pkg::OFS_AGG_FIRST: rdata_nxt = agg_first_r;
				txb_pkg::OFS_PART_FIRST: rdata_nxt = part_first_r;
				txb_pkg::OFS_AGG_SECOND: rdata_nxt = agg_second_r;
				txb_pkg::OFS_PART_SECOND: rdata_nxt = part_second_r;
				txb_pkg::OFS_THRESH: rdata_nxt = thresh_r;
				txb_pkg::OFS_INT_STAT: rdata_nxt = int_stat_r;
				txb_pkg::OFS_INT_MASK: rdata_nxt = int_mask_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		// write-one-to-clear, a new event wins
		int_stat_nxt = int_stat_r;
		if (reg_wr && reg_addr == txb_pkg::OFS_INT_STAT) begin
			int_stat_nxt = int_stat_r & ~reg_wdata;
		end
		int_stat_nxt = int_stat_nxt | events;
		irq_nxt = |(int_stat_nxt & int_mask_r);
	end

	// pointer, level and memory port logic
	always_comb begin
		logic [2:0] p;
		logic [4:0] idx;
		logic [9:0] abs_a;
		logic [9:0] thr;
		logic [3:0] be_any;
		events = 8'h00;
		p = 3'h0;
		idx = 5'h0;
		abs_a = 10'h0;
		thr = 10'h0;
		be_any = 4'h0;
		rd_pend_nxt = 1'b0;
		rd_sel_nxt = rd_sel_r;
		rd_empty_nxt = 1'b0;
		for (int i = 0; i < txb_pkg::NUM_FIFOS; i++) begin
			level_nxt[i] = level_r[i];
			wptr_nxt[i] = wptr_r[i];
			rptr_nxt[i] = rptr_r[i];
		end
		for (int b = 0; b < txb_pkg::NUM_BANKS; b++) begin
			mem_we[b] = 1'b0;
			mem_waddr[b] = 8'h00;
			mem_wdata[b] = 160'h0;
			mem_re[b] = 1'b0;
			mem_raddr[b] = 8'h00;
		end
		// line writes from each group leader
		for (int b = 0; b < txb_pkg::NUM_BANKS; b++) begin
			if (line_valid[b] && txb_pkg::txb_is_leader(b, agg_b[b])) begin
				p = txb_pkg::txb_part_mask(line_part[b], pc_b[b]);
				idx = 5'(b*8) + 5'(p);
				for (int k = 0; k < 4; k++) begin
					be_any[k] = |line_data[b][128 + k*8 + txb_pkg::CTRL_BE_LSB +: 4];
				end
				if (be_any == 4'h0) begin
					events[txb_pkg::INT_DISCARD_LSB + b] = 1'b1;
				end else if (level_r[idx] >= depth_b[b]) begin
					events[txb_pkg::INT_OVERFLOW_LSB + b] = 1'b1;
				end else begin
					abs_a = 10'(b*256) + 10'(10'(p) * depth_b[b]) + {1'b0, wptr_r[idx]};
					mem_we[abs_a[9:8]] = 1'b1;
					mem_waddr[abs_a[9:8]] = abs_a[7:0];
					mem_wdata[abs_a[9:8]] = line_data[b];
					// pointer moves once per stored line
					if ({1'b0, wptr_r[idx]} == depth_b[b] - 10'h1) begin
						wptr_nxt[idx] = 9'h000;
					end else begin
						wptr_nxt[idx] = wptr_r[idx] + 9'h001;
					end
					level_nxt[idx] = level_r[idx] + 10'h001;
				end
			end
		end
		// arbiter drains one line per request
		if (rd_req) begin
			p = txb_pkg::txb_part_mask(rd_part, pc_b[rd_bank]);
			idx = 5'({rd_bank, 3'h0}) + 5'(p);
			if (level_r[idx] == 10'h0) begin
				rd_empty_nxt = 1'b1;
			end else begin
				abs_a = 10'({rd_bank, 8'h00}) + 10'(10'(p) * depth_b[rd_bank])
					+ {1'b0, rptr_r[idx]};
				mem_re[abs_a[9:8]] = 1'b1;
				mem_raddr[abs_a[9:8]] = abs_a[7:0];
				rd_pend_nxt = 1'b1;
				rd_sel_nxt = abs_a[9:8];
				if ({1'b0, rptr_r[idx]} == depth_b[rd_bank] - 10'h1) begin
					rptr_nxt[idx] = 9'h000;
				end else begin
					rptr_nxt[idx] = rptr_r[idx] + 9'h001;
				end
				level_nxt[idx] = level_nxt[idx] - 10'h001;
			end
		end
		// full flag follows level, which moves once per stored or drained line
		for (int i = 0; i < txb_pkg::NUM_FIFOS; i++) begin
			if (thresh_r[i / 8]) begin
				thr = 10'(({2'b0, depth_b[i / 8]} * 12'h003) >> 2);
			end else begin
				thr = depth_b[i / 8];
			end
			full_nxt[i] = level_nxt[i] >= thr;
		end
		rd_valid_nxt = rd_pend_r;
		rd_line_nxt = rd_pend_r ? mem_rdata[rd_sel_r] : rd_line_r;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			agg_first_r <= txb_pkg::RST_AGG;
			part_first_r <= txb_pkg::RST_PART;
			agg_second_r <= txb_pkg::RST_AGG;
			part_second_r <= txb_pkg::RST_PART;
			thresh_r <= txb_pkg::RST_THRESH;
			int_mask_r <= txb_pkg::RST_INT_MASK;
			int_stat_r <= 8'h00;
			rdata_r <= 8'h00;
			irq_r <= 1'b0;
		end else begin
			agg_first_r <= agg_first_nxt;
			part_first_r <= part_first_nxt;
			agg_second_r <= agg_second_nxt;
			part_second_r <= part_second_nxt;
			thresh_r <= thresh_nxt;
			int_mask_r <= int_mask_nxt;
			int_stat_r <= int_stat_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < txb_pkg::NUM_FIFOS; i++) begin
				level_r[i] <= 10'h000;
				wptr_r[i] <= 9'h000;
				rptr_r[i] <= 9'h000;
			end
			full_r <= 32'h0000_0000;
			rd_pend_r <= 1'b0;
			rd_sel_r <= 2'h0;
			rd_valid_r <= 1'b0;
			rd_line_r <= 160'h0;
			rd_empty_r <= 1'b0;
		end else begin
			for (int i = 0; i < txb_pkg::NUM_FIFOS; i++) begin
				level_r[i] <= level_nxt[i];
				wptr_r[i] <= wptr_nxt[i];
				rptr_r[i] <= rptr_nxt[i];
			end
			full_r <= full_nxt;
			rd_pend_r <= rd_pend_nxt;
			rd_sel_r <= rd_sel_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_line_r <= rd_line_nxt;
			rd_empty_r <= rd_empty_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign part_full = full_r;
	assign rd_valid = rd_valid_r;
	assign rd_data = rd_line_r[127:0];
	assign rd_ctrl = rd_line_r[159:128];
	assign rd_empty = rd_empty_r;
	assign irq = irq_r;
endmodule

// File: src/txb_line_asm.sv
// gathers 32/64/128-bit writes into 160-bit lines, closing a line early on end of packet
`timescale 1ns/100ps
module txb_line_asm (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] agg,
	input wire logic wr_en,
	input wire logic [2:0] wr_part,
	input wire logic [127:0] wr_data,
	input wire logic [31:0] wr_ctrl,
	txb_line_if.src out
);
	logic [1:0] pos_r;
	logic [1:0] pos_nxt;
	logic [127:0] dat_r;
	logic [127:0] dat_nxt;
	logic [31:0] ctl_r;
	logic [31:0] ctl_nxt;
	logic valid_r;
	logic valid_nxt;
	logic [2:0] part_r;
	logic [2:0] part_nxt;
	logic [159:0] line_r;
	logic [159:0] line_nxt;

	assign out.valid = valid_r;
	assign out.part = part_r;
	assign out.line = line_r;

	always_comb begin
		logic [2:0] n;
		logic [2:0] sum;
		logic [1:0] tgt;
		logic eop;
		logic [127:0] md;
		logic [31:0] mc;
		n = txb_pkg::txb_lanes(agg);
		sum = 3'({1'b0, pos_r} + n);
		md = dat_r;
		mc = ctl_r;
		eop = 1'b0;
		tgt = 2'h0;
		pos_nxt = pos_r;
		dat_nxt = dat_r;
		ctl_nxt = ctl_r;
		valid_nxt = 1'b0;
		part_nxt = part_r;
		line_nxt = line_r;
		if (wr_en) begin
			for (int k = 0; k < 4; k++) begin
				if (3'(k) < n) begin
					tgt = 2'(pos_r + 2'(k));
					md[tgt*32 +: 32] = wr_data[k*32 +: 32];
					mc[tgt*8 +: 8] = wr_ctrl[k*8 +: 8];
					eop = eop | wr_ctrl[k*8 + txb_pkg::CTRL_EOP_BIT];
				end
			end
			if (sum[2] || eop) begin
				// line complete or cut short by end of packet
				valid_nxt = 1'b1;
				part_nxt = wr_part;
				line_nxt = {mc, md};
				pos_nxt = 2'h0;
				dat_nxt = 128'h0;
				ctl_nxt = 32'h0;
			end else begin
				pos_nxt = sum[1:0];
				dat_nxt = md;
				ctl_nxt = mc;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pos_r <= 2'h0;
			dat_r <= 128'h0;
			ctl_r <= 32'h0;
			valid_r <= 1'b0;
			part_r <= 3'h0;
			line_r <= 160'h0;
		end else begin
			pos_r <= pos_nxt;
			dat_r <= dat_nxt;
			ctl_r <= ctl_nxt;
			valid_r <= valid_nxt;
			part_r <= part_nxt;
			line_r <= line_nxt;
		end
	end
endmodule

// File: src/txb_line_if.sv
// completed 160-bit line handed from an assembler to the pointer logic
`timescale 1ns/100ps
interface txb_line_if;
	logic valid;
	logic [2:0] part;
	logic [159:0] line;
	modport src (output valid, output part, output line);
	modport dst (input valid, input part, input line);
endinterface

// File: src/txb_pkg.sv
// constants and helpers for the partitioned transmit buffer
// Behaviour
// - four banks, each 256 lines of 160 bits, data plus sideband control
// - each bank splits into up to eight equal partitions, thirty-two in all
// - block keeps write and read pointers for every partition itself
// - per-partition full flag with programmable threshold goes back to the writer
// - writes arrive over 32-bit, 64-bit or one 128-bit port per bank mode
// - every write port carries its own sideband control bus
// - 32-bit single partition holds 2K bytes; doubles with width, halves per split
// - width and partition count per bank come from software registers per interface
// - width field two bits per bank: 00 32-bit, 01 64-bit, 10 128-bit; bank 0 bits 0:1
// - partition field: 00 one, 01 two, 10 four, 11 eight, any width
// - bank one fields at bits 2:3, bank two fields at bits 4:5
// - writer fills whole 128-bit lines; pointer moves only after a full line (also after a line cut short by end of packet)
// - a line with all sixteen byte enables clear is dropped, pointer unchanged
// - threshold is 3/4 or full; flag updates per line, holds until below
package txb_pkg;
	localparam int NUM_BANKS = 4;
	localparam int NUM_PARTS = 8;
	localparam int NUM_FIFOS = 32;
	localparam int BANK_LINES = 256;
	localparam int LINE_W = 160;
	localparam int LANE_W = 32;
	localparam int CTRL_W = 8;
	localparam int REG_ADDR_W = 20;
	localparam int REG_DATA_W = 8;
	localparam logic [19:0] OFS_AGG_FIRST = 20'h30903;
	localparam logic [19:0] OFS_PART_FIRST = 20'h30927;
	localparam logic [19:0] OFS_PART_SECOND = 20'h30A27;
	localparam logic [19:0] OFS_AGG_SECOND = 20'h30A30;
	localparam logic [19:0] OFS_THRESH = 20'h30940;
	localparam logic [19:0] OFS_INT_STAT = 20'h30941;
	localparam logic [19:0] OFS_INT_MASK = 20'h30942;
	localparam logic [7:0] RST_AGG = 8'h00;
	localparam logic [7:0] RST_PART = 8'h00;
	localparam logic [7:0] RST_THRESH = 8'h00;
	localparam logic [7:0] RST_INT_MASK = 8'h00;
	localparam int FIELD_W = 2;
	localparam int INT_DISCARD_LSB = 0;
	localparam int INT_OVERFLOW_LSB = 4;
	localparam int CTRL_BE_LSB = 0;
	localparam int CTRL_EOP_BIT = 4;
	localparam logic [1:0] AGG_32 = 2'h0;
	localparam logic [1:0] AGG_64 = 2'h1;
	localparam logic [1:0] AGG_128 = 2'h2;
	localparam logic [1:0] AGG_RSVD = 2'h3;
	// 2K bytes in 16-byte lines
	localparam logic [9:0] BASE_DEPTH_LINES = 10'h080;

	function automatic logic [1:0] txb_agg_clean(input logic [1:0] agg);
		return (agg == AGG_RSVD) ? AGG_32 : agg;
	endfunction

	function automatic logic [9:0] txb_depth(input logic [1:0] agg, input logic [1:0] pc);
		return (BASE_DEPTH_LINES << txb_agg_clean(agg)) >> pc;
	endfunction

	function automatic logic [2:0] txb_part_mask(input logic [2:0] part, input logic [1:0] pc);
		return part & 3'((4'h1 << pc) - 4'h1);
	endfunction

	function automatic logic txb_is_leader(input int b, input logic [1:0] agg);
		logic [1:0] a;
		a = txb_agg_clean(agg);
		if (a == AGG_64) begin
			return (b % 2) == 0;
		end
		if (a == AGG_128) begin
			return b == 0;
		end
		return 1'b1;
	endfunction

	function automatic logic [2:0] txb_lanes(input logic [1:0] agg);
		logic [1:0] a;
		a = txb_agg_clean(agg);
		if (a == AGG_64) begin
			return 3'h2;
		end
		if (a == AGG_128) begin
			return 3'h4;
		end
		return 3'h1;
	endfunction
endpackage

// File: tb/testbench.sv
// self-checking bench for the partitioned transmit buffer
`timescale 1ns/100ps
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [19:0] reg_addr = 20'h00000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_req = 1'b0;
	logic [1:0] rd_bank = 2'h0;
	logic [2:0] rd_part = 3'h0;
	logic [7:0] reg_rdata;
	logic [3:0] wr_en;
	logic [11:0] wr_part;
	logic [127:0] wr_data, rd_data;
	logic [31:0] wr_ctrl, part_full, rd_ctrl;
	logic rd_valid, rd_empty, irq;
	int num_errors = 0;
	int tests_run = 0;
	always #5 clock = ~clock;
	txb_writer u_wr (.clock(clock), .wr_en(wr_en), .wr_part(wr_part), .wr_data(wr_data),
		.wr_ctrl(wr_ctrl));
	txb_fifo_banks #(.USE_SECOND(1'b0)) u_dut (.clock(clock), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .wr_en(wr_en), .wr_part(wr_part), .wr_data(wr_data),
		.wr_ctrl(wr_ctrl), .part_full(part_full), .rd_req(rd_req), .rd_bank(rd_bank),
		.rd_part(rd_part), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ctrl(rd_ctrl),
		.rd_empty(rd_empty), .irq(irq));
	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic reg_write(input logic [19:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_check(input logic [19:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", 128'(exp), 128'(reg_rdata));
	endtask
	// lanes with clear byte enables in ctl are expected to read back as zero
	task automatic read_line(input logic [1:0] b, input logic [2:0] p, input logic empty,
		input logic [31:0] seed, input logic [31:0] ctl = 32'h0F0F0F0F);
		logic [127:0] want;
		@(posedge clock);
		rd_req <= 1'b1;
		rd_bank <= b;
		rd_part <= p;
		@(posedge clock);
		rd_req <= 1'b0;
		#1;
		chk("rd_empty", 128'(empty), 128'(rd_empty));
		@(posedge clock);
		#1;
		chk("rd_valid", 128'(!empty), 128'(rd_valid));
		if (!empty) begin
			for (int k = 0; k < 4; k++) begin
				want[32*k +: 32] = (ctl[8*k +: 4] != 4'h0) ? seed + 32'(k) : 32'h0;
			end
			chk("rd_data", want, rd_data);
			chk("rd_ctrl", 128'(ctl), 128'(rd_ctrl));
		end
	endtask
	task automatic t_regs();
		logic [19:0] a [6];
		logic [7:0] v [6];
		a = '{txb_pkg::OFS_AGG_FIRST, txb_pkg::OFS_PART_FIRST, txb_pkg::OFS_PART_SECOND,
			txb_pkg::OFS_AGG_SECOND, txb_pkg::OFS_THRESH, txb_pkg::OFS_INT_MASK};
		v = '{8'h50, 8'h0F, 8'h1B, 8'hE4, 8'h02, 8'h11};
		for (int i = 0; i < 6; i++) begin
			reg_check(a[i], 8'h00);
		end
		for (int i = 0; i < 6; i++) begin
			reg_write(a[i], v[i]);
		end
		for (int i = 0; i < 6; i++) begin
			reg_check(a[i], v[i]);
		end
		reg_check(20'h30000, 8'h00);
	endtask
	// bank 0, eight partitions, 16 lines each
	task automatic t_fill();
		for (int n = 0; n < 16; n++) begin
			u_wr.put_line(0, 1, 3'h5, 32'h00001000 + 32'(n * 16), 4'hF);
			settle();
			chk("full", 128'((n == 15) ? 32'h00000020 : 32'h00000000), 128'(part_full));
		end
		u_wr.put_line(0, 1, 3'h5, 32'h0000DEAD, 4'hF);
		settle();
		chk("irq", 128'(1'b1), 128'(irq));
		reg_check(txb_pkg::OFS_INT_STAT, 8'h10);
		read_line(2'h0, 3'h5, 1'b0, 32'h00001000);
		settle();
		chk("full", 128'h0, 128'(part_full));
		reg_write(txb_pkg::OFS_INT_STAT, 8'h10);
		settle();
		chk("irq", 128'h0, 128'(irq));
	endtask
	// bank 1 at 3/4 threshold trips at 12 lines
	task automatic t_thr();
		for (int n = 0; n < 12; n++) begin
			u_wr.put_line(1, 1, 3'h2, 32'h00002000, 4'hF);
			settle();
			chk("full", 128'((n == 11) ? 32'h00000400 : 32'h00000000), 128'(part_full));
		end
	endtask
	task automatic t_disc();
		u_wr.put_line(0, 1, 3'h1, 32'h00000005, 4'h0);
		settle();
		chk("irq", 128'(1'b1), 128'(irq));
		reg_check(txb_pkg::OFS_INT_STAT, 8'h01);
		read_line(2'h0, 3'h1, 1'b1, 32'h0);
		read_line(2'h0, 3'h4, 1'b1, 32'h0);
		reg_write(txb_pkg::OFS_INT_MASK, 8'h00);
		settle();
		chk("irq", 128'h0, 128'(irq));
		reg_write(txb_pkg::OFS_INT_MASK, 8'h11);
		reg_write(txb_pkg::OFS_INT_STAT, 8'h01);
		settle();
		chk("irq", 128'h0, 128'(irq));
		reg_check(txb_pkg::OFS_INT_STAT, 8'h00);
		// one write with end of packet closes a short line
		u_wr.put_line(0, 1, 3'h3, 32'h00000300, 4'hF, 1'b1);
		settle();
		read_line(2'h0, 3'h3, 1'b0, 32'h00000300, 32'h0000001F);
	endtask
	// banks 2 and 3 as one 64-bit group with a single partition
	task automatic t_wide();
		u_wr.put_line(2, 2, 3'h7, 32'h00007000, 4'hF);
		settle();
		read_line(2'h2, 3'h0, 1'b0, 32'h00007000);
	endtask
	// reset in mid-run, then all banks as one 128-bit group of four partitions
	task automatic t_all128();
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk("full", 128'h0, 128'(part_full));
		reg_check(txb_pkg::OFS_PART_FIRST, 8'h00);
		reg_write(txb_pkg::OFS_AGG_FIRST, 8'hAA);
		reg_write(txb_pkg::OFS_PART_FIRST, 8'hAA);
		u_wr.put_line(0, 4, 3'h6, 32'h0000A000, 4'hF);
		settle();
		read_line(2'h0, 3'h2, 1'b0, 32'h0000A000);
		read_line(2'h0, 3'h6, 1'b1, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_fill();
		t_thr();
		t_disc();
		t_wide();
		t_all128();
		finish_test();
	end
	initial begin
		#100000;
		num_errors++;
		finish_test();
	end
endmodule

// File: tb/txb_sva.sv
// port assertions for the partitioned transmit buffer
`timescale 1ns/100ps
module txb_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] wr_en,
	input wire logic [31:0] part_full,
	input wire logic rd_req,
	input wire logic rd_valid,
	input wire logic [127:0] rd_data,
	input wire logic [31:0] rd_ctrl,
	input wire logic rd_empty
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_answer;
		rd_req |=> (rd_empty ##1 !rd_valid) or (!rd_empty ##1 rd_valid);
	endproperty
	a_answer: assert property (p_answer) else $error("read request unanswered");
	property p_valid_cause;
		rd_valid |-> $past(rd_req, 2);
	endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("stray read valid");
	property p_empty_cause;
		rd_empty |-> $past(rd_req) && !rd_valid;
	endproperty
	a_empty_cause: assert property (p_empty_cause) else $error("stray empty pulse");
	property p_full_rise;
		(part_full & ~$past(part_full)) != 32'h00000000 |-> $past(wr_en, 2) != 4'h0;
	endproperty
	a_full_rise: assert property (p_full_rise) else $error("full rose without a line");
	property p_full_fall;
		($past(part_full) & ~part_full) != 32'h00000000 |-> $past(rd_req);
	endproperty
	a_full_fall: assert property (p_full_fall) else $error("full fell without a read");
	property p_data_hold;
		!rd_valid |-> $stable(rd_data);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("read data moved");
	property p_ctrl_hold;
		!rd_valid |-> $stable(rd_ctrl);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("read control moved");
	c_full: cover property ($rose(part_full[5]));
	c_empty: cover property (rd_empty);
	c_valid: cover property (rd_valid);
endmodule

bind txb_fifo_banks txb_sva u_sva (.clock(clock), .rst(rst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .wr_en(wr_en), .part_full(part_full), .rd_req(rd_req),
	.rd_valid(rd_valid), .rd_data(rd_data), .rd_ctrl(rd_ctrl), .rd_empty(rd_empty));

// File: tb/txb_writer.sv
// fabric-side writer model for the per-bank write ports
`timescale 1ns/100ps
module txb_writer (
	input wire logic clock,
	output logic [3:0] wr_en,
	output logic [11:0] wr_part,
	output logic [127:0] wr_data,
	output logic [31:0] wr_ctrl
);
	initial begin
		wr_en = 4'h0;
		wr_part = 12'h000;
		wr_data = 128'h0;
		wr_ctrl = 32'h00000000;
	end
	// one whole line in 4/lanes writes, line lane k carries seed+k
	// cut ends the line after one write, end of packet set on every written lane
	task automatic put_line(input int bank, input int lanes, input logic [2:0] part,
		input logic [31:0] seed, input logic [3:0] be, input bit cut = 1'b0);
		for (int w = 0; w < (cut ? 1 : 4 / lanes); w++) begin
			@(posedge clock);
			for (int j = 0; j < 4; j++) begin
				wr_en[j] <= (j >= bank && j < bank + lanes);
				wr_part[3*j +: 3] <= part;
				wr_data[32*j +: 32] <= seed + 32'(w * lanes + j - bank);
				wr_ctrl[8*j +: 8] <= {3'h0, cut, be};
			end
		end
		@(posedge clock);
		wr_en <= 4'h0;
		wr_data <= ~wr_data;
		wr_part <= ~wr_part;
	endtask
endmodule
